/* File: design/dbgerr_debug_unit.sv */
/*
  Debug line error handling, break generation, breakpoint control and the
  multipurpose debug counter of the on-chip debug unit.
  Assumes an external baud detector, command parser and core handshake, all
  on sys_clk; the debug line has an external pull-up.

*/
`timescale 1ns/1ps
`default_nettype none
module dbgerr_debug_unit
  import dbgerr_pkg::*;
#(
  parameter int TX_DEPTH = FIFO_DEPTH
) (
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  input  wire logic                    debug_line_in,
  output logic                         debug_line_out,
  output logic                         debug_line_oe_n,
  input  wire logic                    baud_locked,
  input  wire logic [BIT_PERIOD_W-1:0] bit_period,
  output logic                         baud_reset,
  input  wire logic                    clk_switch,
  output logic                         cmd_abort,
  output logic                         cmd_full_enable,
  output logic [7:0]                   rx_byte,
  output logic                         rx_strobe,
  input  wire logic [7:0]              tx_data,
  input  wire logic                    tx_valid,
  output logic                         tx_ready,
  input  wire logic                    ctl_wr,
  input  wire logic [7:0]              ctl_wdata,
  output logic [7:0]                   ctl_rdata,
  output logic [7:0]                   status_rdata,
  input  wire logic                    cnt_wr,
  input  wire logic [CNT_W-1:0]        cnt_wdata,
  input  wire logic                    cnt_byte_dec,
  output logic [CNT_W-1:0]             cnt_rdata,
  input  wire logic                    brk_decoded,
  input  wire logic                    pc_fetch,
  input  wire logic [CNT_W-1:0]        pc,
  output logic                         core_stop,
  output logic                         core_loop
);
  dbgerr_link_state_type link;
  dbgerr_link_state_type next_link;
  logic [SEND_W-1:0]     send_tmr;
  logic [SEND_W-1:0]     next_send_tmr;
  logic [LOW_CNT_W-1:0]  low_cnt;
  logic [LOW_CNT_W-1:0]  next_low_cnt;
  logic [LOW_CNT_W-1:0]  brk_thresh;
  logic                  rx_break;
  logic                  link_err;
  logic                  held;
  logic                  next_abort;
  logic                  next_baud_reset;
  logic                  next_oe_n;

  dbgerr_ctl_type        ctl;
  dbgerr_ctl_type        next_ctl;
  logic                  dbg_prev;
  logic                  looping;
  logic                  next_looping;
  logic [CNT_W-1:0]      cnt;
  logic [CNT_W-1:0]      next_cnt;
  logic                  exiting;
  logic                  running;
  logic                  hit;
  logic [7:0]            next_status;

  logic                  ser_drive_low;
  logic                  fifo_valid;
  logic [7:0]            fifo_data;
  logic                  fifo_take;
  dbgerr_rx_type         ser_rx;

  function automatic logic counting_mode(input dbgerr_cnt_mode_type m);
    counting_mode = (m == CM_CYCLES) || (m == CM_DOWN);
  endfunction

  assign held = (link != LK_RUN);

  // tx bytes queue here so the parser can run ahead of the line
  dbgerr_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (TX_DEPTH)
  ) i_dbgerr_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .flush     (held),
    .in_valid  (tx_valid),
    .in_data   (tx_data),
    .in_ready  (tx_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_take)
  );

  dbgerr_serial i_dbgerr_serial (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .abort      (held),
    .baud_ok    (baud_locked),
    .bit_period (bit_period),
    .line_in    (debug_line_in),
    .tx_valid   (fifo_valid),
    .tx_data    (fifo_data),
    .tx_take    (fifo_take),
    .drive_low  (ser_drive_low),
    .rx         (ser_rx)
  );

  assign rx_byte   = ser_rx.data;
  assign rx_strobe = ser_rx.strobe;

  // link error and break sequencing
  always_comb begin
    next_link       = link;
    next_send_tmr   = send_tmr;
    next_abort      = 1'b0;
    brk_thresh      = LOW_CNT_W'(bit_period) * LOW_CNT_W'(BREAK_BITS);
    // own break is not counted, a host break extending it is
    if (!debug_line_in && link != LK_SEND && low_cnt != '1) begin
      next_low_cnt = low_cnt + 1'b1;
    end else if (!debug_line_in && link != LK_SEND) begin
      next_low_cnt = low_cnt;
    end else begin
      next_low_cnt = '0;
    end
    rx_break = baud_locked && bit_period != '0 && low_cnt >= brk_thresh;
    link_err = rx_break | ser_rx.frame_err | ser_rx.collision;
    case (link)
      LK_RUN: begin
        if (link_err || (clk_switch && baud_locked)) begin
          next_link     = LK_SEND;
          next_send_tmr = '0;
          next_abort    = 1'b1;
        end
      end
      LK_SEND: begin
        next_send_tmr = send_tmr + 1'b1;
        if (send_tmr == SEND_W'(SEND_BREAK_CYCLES - 1)) begin
          next_link = LK_HOLD;
        end
      end
      LK_HOLD: begin
        if (debug_line_in) begin
          next_link = LK_RUN;
        end
      end
      default: next_link = LK_RUN;
    endcase
    next_baud_reset = (next_link != LK_RUN);
    next_oe_n       = ~((next_link == LK_SEND) | ser_drive_low);
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      link            <= LK_RUN;
      send_tmr        <= '0;
      low_cnt         <= '0;
      cmd_abort       <= 1'b0;
      baud_reset      <= 1'b1;
      debug_line_oe_n <= 1'b1;
      debug_line_out  <= 1'b0;
    end else begin
      link            <= next_link;
      send_tmr        <= next_send_tmr;
      low_cnt         <= next_low_cnt;
      cmd_abort       <= next_abort;
      baud_reset      <= next_baud_reset;
      debug_line_oe_n <= next_oe_n;
      debug_line_out  <= 1'b0;
    end
  end

  // breakpoints, debug mode and counter
  always_comb begin
    next_ctl     = ctl;
    next_looping = looping;
    next_cnt     = cnt;
    exiting      = dbg_prev & ~ctl.debug_mode_bit;
    running      = ~ctl.debug_mode_bit;
    hit          = 1'b0;
    if (ctl_wr) begin
      next_ctl = dbgerr_ctl_type'(ctl_wdata);
    end
    if (brk_decoded && running && ctl.bp_enable) begin
      if (ctl.break_loop_bit) begin
        next_looping = 1'b1;
      end else begin
        hit = 1'b1;
      end
    end
    if (running && ctl.cnt_mode == CM_DOWN && !exiting && cnt == CNT_ZERO) begin
      hit = 1'b1;
    end
    if (running && ctl.cnt_mode == CM_MATCH && pc_fetch && pc == cnt) begin
      hit = 1'b1;
    end
    if (hit) begin
      // hardware entry beats a same-cycle software clear
      next_ctl.debug_mode_bit = 1'b1;
      next_looping            = 1'b0;
    end
    if (cnt_wr && ctl.debug_mode_bit) begin
      next_cnt = cnt_wdata;
    end else if (cnt_byte_dec && ctl.debug_mode_bit && cnt != CNT_ZERO) begin
      next_cnt = cnt - 1'b1;
    end else if (exiting && ctl.cnt_mode == CM_CYCLES) begin
      next_cnt = CNT_MAX;
    end else if (running && !exiting && counting_mode(ctl.cnt_mode) &&
                 cnt != CNT_ZERO) begin
      next_cnt = cnt - 1'b1;
    end
    next_status                = '0;
    next_status[STAT_DBG_MODE] = next_ctl.debug_mode_bit;
    next_status[STAT_IDLE]     = next_looping;
    next_status[STAT_HOLD]     = next_link != LK_RUN;
    next_status[STAT_LOCK]     = baud_locked;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctl             <= dbgerr_ctl_type'(CTL_RESET);
      dbg_prev        <= 1'b0;
      looping         <= 1'b0;
      cnt             <= CNT_RESET;
      ctl_rdata       <= CTL_RESET;
      status_rdata    <= 8'h00;
      cnt_rdata       <= ~CNT_RESET;
      cmd_full_enable <= 1'b0;
      core_stop       <= 1'b0;
      core_loop       <= 1'b0;
    end else begin
      ctl             <= next_ctl;
      dbg_prev        <= ctl.debug_mode_bit;
      looping         <= next_looping;
      cnt             <= next_cnt;
      ctl_rdata       <= next_ctl;
      status_rdata    <= next_status;
      cnt_rdata       <= ~next_cnt;
      cmd_full_enable <= next_ctl.debug_mode_bit;
      core_stop       <= next_ctl.debug_mode_bit;
      core_loop       <= next_ctl.bp_enable & next_ctl.break_loop_bit;
    end
  end
endmodule
`default_nettype wire

/* File: design/dbgerr_fifo.sv */
/*
  Flop based FIFO with valid/ready on both sides and a synchronous flush.
  Assumes one clock; full and empty are registered flags.
*/
`timescale 1ns/1ps
`default_nettype none
module dbgerr_fifo
  import dbgerr_pkg::*;
#(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             flush,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    wr_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW:0]      next_count;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full      = ~in_ready;
  assign out_valid = ~empty;
  assign out_data  = mem[rd_ptr];

  always_comb begin
    push        = in_valid & ~full & ~flush;
    pop         = out_ready & ~empty & ~flush;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
    if (!resetn) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
      in_ready <= 1'b1;
      empty  <= 1'b1;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count  <= next_count;
      // ready kept as its own flop so the port comes straight from a register
      in_ready <= (next_count != (AW+1)'(DEPTH));
      empty  <= (next_count == '0);
    end
  end
endmodule
`default_nettype wire

/* File: design/dbgerr_pkg.sv */
/*
  Shared constants and types for the debug line error and breakpoint block.
  Assumes a single 100 MHz system clock domain.
*/
package dbgerr_pkg;

  localparam int SYS_CLK_MHZ       = 100;
  localparam int BREAK_BITS        = 10;
  localparam int SEND_BREAK_CYCLES = 4096;
  localparam int SEND_W            = $clog2(SEND_BREAK_CYCLES);
  localparam int BIT_PERIOD_W      = 9;
  localparam int LOW_CNT_W         = 13;
  localparam int CHAR_LAST_BIT     = 9;
  localparam int FIFO_DEPTH        = 16;
  localparam int BYTE_W            = 8;
  localparam int CNT_W             = 16;

  localparam logic [CNT_W-1:0] CNT_MAX   = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [7:0]       CTL_RESET = 8'h00;
  localparam logic [7:0]       BRK_OPCODE = 8'h00;

  localparam int STAT_DBG_MODE = 7;
  localparam int STAT_IDLE     = 5;
  localparam int STAT_HOLD     = 4;
  localparam int STAT_LOCK     = 0;

  typedef enum logic [1:0] {
    CM_OFF    = 2'h0,
    CM_CYCLES = 2'h1,
    CM_DOWN   = 2'h2,
    CM_MATCH  = 2'h3
  } dbgerr_cnt_mode_type;

  typedef struct packed {
    logic                debug_mode_bit;
    logic                bp_enable;
    logic                break_loop_bit;
    logic [2:0]          spare;
    dbgerr_cnt_mode_type cnt_mode;
  } dbgerr_ctl_type;

  typedef enum logic [2:0] {
    LK_RUN  = 3'b001,
    LK_SEND = 3'b010,
    LK_HOLD = 3'b100
  } dbgerr_link_state_type;

  typedef enum logic [2:0] {
    SR_IDLE = 3'b001,
    SR_RX   = 3'b010,
    SR_TX   = 3'b100
  } dbgerr_ser_state_type;

  typedef struct packed {
    logic        frame_err;
    logic        collision;
    logic [7:0]  data;
    logic        strobe;
  } dbgerr_rx_type;

endpackage

/* File: design/dbgerr_serial.sv */
/*
  Half duplex 8N1 character engine for the debug line: receive with framing
  check, transmit with collision check. Assumes a bit period from the baud
  detector and a line already synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dbgerr_serial
  import dbgerr_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  input  wire logic                    abort,
  input  wire logic                    baud_ok,
  input  wire logic [BIT_PERIOD_W-1:0] bit_period,
  input  wire logic                    line_in,
  input  wire logic                    tx_valid,
  input  wire logic [7:0]              tx_data,
  output logic                         tx_take,
  output logic                         drive_low,
  output dbgerr_rx_type                rx
);
  dbgerr_ser_state_type    state;
  dbgerr_ser_state_type    next_state;
  logic [BIT_PERIOD_W-1:0] tmr;
  logic [BIT_PERIOD_W-1:0] next_tmr;
  logic [3:0]              idx;
  logic [3:0]              next_idx;
  logic [9:0]              shreg;
  logic [9:0]              next_shreg;
  logic                    next_drive_low;
  dbgerr_rx_type           next_rx;
  logic                    mid;
  logic                    last;

  always_comb begin
    next_state     = state;
    next_tmr       = tmr + 1'b1;
    next_idx       = idx;
    next_shreg     = shreg;
    next_rx        = '0;
    next_rx.data   = rx.data;
    tx_take        = 1'b0;
    mid            = (tmr == (bit_period >> 1));
    last           = (tmr == bit_period - 1'b1);
    if (last) begin
      next_tmr = '0;
      next_idx = idx + 1'b1;
    end
    case (state)
      SR_IDLE: begin
        next_tmr = '0;
        next_idx = '0;
        if (baud_ok && !line_in) begin
          next_state = SR_RX;
        end else if (baud_ok && tx_valid) begin
          tx_take    = 1'b1;
          next_shreg = {1'b1, tx_data, 1'b0};
          next_state = SR_TX;
        end
      end
      SR_RX: begin
        if (mid) begin
          if (idx == 4'd0 && line_in) begin
            next_state = SR_IDLE;
          end else if (idx == 4'(CHAR_LAST_BIT)) begin
            next_rx.frame_err = ~line_in;
            next_rx.strobe    = line_in;
            // nine right shifts, start bit first, leave the first data bit at position 2
            next_rx.data      = shreg[9:2];
            next_state        = SR_IDLE;
          end else begin
            next_shreg = {line_in, shreg[9:1]};
          end
        end
      end
      SR_TX: begin
        // released one bit but the line reads low: the host is driving
        if (mid && shreg[0] && !line_in) begin
          next_rx.collision = 1'b1;
          next_state        = SR_IDLE;
        end else if (last) begin
          next_shreg = {1'b1, shreg[9:1]};
          if (idx == 4'(CHAR_LAST_BIT)) begin
            next_state = SR_IDLE;
          end
        end
      end
      default: next_state = SR_IDLE;
    endcase
    if (abort) begin
      next_state = SR_IDLE;
      tx_take    = 1'b0;
      next_rx    = '0;
    end
    next_drive_low = (next_state == SR_TX) & ~next_shreg[0];
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state     <= SR_IDLE;
      tmr       <= '0;
      idx       <= '0;
      shreg     <= '1;
      drive_low <= 1'b0;
      rx        <= '0;
    end else begin
      state     <= next_state;
      tmr       <= next_tmr;
      idx       <= next_idx;
      shreg     <= next_shreg;
      drive_low <= next_drive_low;
      rx        <= next_rx;
    end
  end
endmodule
`default_nettype wire

/* File: test/dbgerr_debug_props.sv */
/*
  Concurrent checks on the ports of the debug error and breakpoint block.
  Assumes one sys_clk domain with synchronous active-low resetn.
*/
`timescale 1ns/1ps
`default_nettype none
module dbgerr_debug_props (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        debug_line_in,
  input wire logic        debug_line_oe_n,
  input wire logic        baud_locked,
  input wire logic        baud_reset,
  input wire logic        clk_switch,
  input wire logic        cmd_abort,
  input wire logic        cmd_full_enable,
  input wire logic        ctl_wr,
  input wire logic [7:0]  ctl_rdata,
  input wire logic [7:0]  status_rdata,
  input wire logic [15:0] cnt_rdata,
  input wire logic        brk_decoded,
  input wire logic        pc_fetch,
  input wire logic [15:0] pc,
  input wire logic        core_stop
);
  logic        in_brk;
  logic [12:0] brk_run;
  // own break length, counted from the abort pulse
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      in_brk  <= 1'b0;
      brk_run <= 13'h0000;
    end else if (cmd_abort) begin
      in_brk  <= 1'b1;
      brk_run <= 13'h0001;
    end else if (debug_line_oe_n) begin
      in_brk <= 1'b0;
    end else begin
      brk_run <= brk_run + 13'h0001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_brk_out;
    !debug_line_oe_n && baud_reset;
  endsequence
  sequence s_stopped;
    core_stop && status_rdata[7];
  endsequence
  property p_abort;
    cmd_abort |-> s_brk_out [*8];
  endproperty
  property p_brk_len;
    $rose(debug_line_oe_n) && in_brk |-> brk_run == 13'h1000;
  endproperty
  property p_clk_sw;
    clk_switch && baud_locked && !baud_reset && !cmd_abort |=> cmd_abort;
  endproperty
  property p_hold;
    baud_reset && !debug_line_in |=> baud_reset;
  endproperty
  property p_brk_stop;
    brk_decoded && ctl_rdata[6] && !ctl_rdata[5] && !ctl_wr |=> s_stopped;
  endproperty
  property p_brk_nop;
    brk_decoded && !ctl_rdata[6] && !ctl_rdata[1] && !core_stop && !ctl_wr && !pc_fetch
      |=> !core_stop;
  endproperty
  property p_idle;
    brk_decoded && ctl_rdata[6] && ctl_rdata[5] && !core_stop && !ctl_wr
      |=> status_rdata[5];
  endproperty
  property p_full;
    cmd_full_enable == ctl_rdata[7];
  endproperty
  property p_count;
    ctl_rdata[1:0] == 2'h1 && !ctl_rdata[7] && !ctl_wr && !brk_decoded && !pc_fetch
      && !$past(ctl_rdata[7]) && cnt_rdata != 16'hFFFF
      |=> cnt_rdata == $past(cnt_rdata) + 16'h0001;
  endproperty
  property p_off;
    ctl_rdata[1:0] == 2'h0 && !ctl_rdata[7] && !ctl_wr |=> $stable(cnt_rdata);
  endproperty
  property p_match;
    pc_fetch && ctl_rdata[1:0] == 2'h3 && !ctl_rdata[7] && !ctl_wr && pc == ~cnt_rdata
      |=> core_stop;
  endproperty
  a_abort: assert property (p_abort) else $error("abort without break");
  a_brk_len: assert property (p_brk_len) else $error("break length wrong");
  a_clk_sw: assert property (p_clk_sw) else $error("clock switch ignored");
  a_hold: assert property (p_hold) else $error("released while line low");
  a_brk_stop: assert property (p_brk_stop) else $error("breakpoint missed");
  a_brk_nop: assert property (p_brk_nop) else $error("disabled breakpoint stopped");
  a_idle: assert property (p_idle) else $error("idle bit not set");
  a_full: assert property (p_full) else $error("command enable wrong");
  a_count: assert property (p_count) else $error("cycle count wrong");
  a_off: assert property (p_off) else $error("counter moved");
  a_match: assert property (p_match) else $error("address match missed");
endmodule
bind dbgerr_debug_unit dbgerr_debug_props i_dbgerr_debug_props (
  .sys_clk(sys_clk), .resetn(resetn), .debug_line_in(debug_line_in),
  .debug_line_oe_n(debug_line_oe_n), .baud_locked(baud_locked), .baud_reset(baud_reset),
  .clk_switch(clk_switch), .cmd_abort(cmd_abort), .cmd_full_enable(cmd_full_enable),
  .ctl_wr(ctl_wr), .ctl_rdata(ctl_rdata), .status_rdata(status_rdata),
  .cnt_rdata(cnt_rdata), .brk_decoded(brk_decoded), .pc_fetch(pc_fetch), .pc(pc),
  .core_stop(core_stop)
);
`default_nettype wire

/* File: test/dbgerr_host.sv */
/*
  Host serial port model on the open-drain debug line.
  Assumes the bench resolves the wire with a pull-up; pull high = drive low.
*/
`timescale 1ns/1ps
`default_nettype none
module dbgerr_host #(
  parameter int BIT = 8
) (
  input  wire logic sys_clk,
  input  wire logic line,
  input  wire logic listen,
  output logic      pull
);
  logic [7:0] rx_q[$];
  logic [7:0] rb;
  int         j;
  initial pull = 1'b0;
  // allowed even over the device's own transmission
  task automatic hold_low(input int n);
    @(posedge sys_clk);
    pull <= 1'b1;
    repeat (n) @(posedge sys_clk);
    pull <= 1'b0;
  endtask
  task automatic send_char(input logic [7:0] b, input logic stop_ok);
    @(posedge sys_clk);
    pull <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge sys_clk);
      pull <= (i < 8) ? !b[i] : !stop_ok;
    end
    repeat (BIT) @(posedge sys_clk);
    pull <= 1'b0;
  endtask
  // mid-bit sampling, stop bit not judged
  always begin
    @(posedge sys_clk);
    if (listen && !pull && !line) begin
      repeat (BIT / 2) @(posedge sys_clk);
      for (j = 0; j < 8; j++) begin
        repeat (BIT) @(posedge sys_clk);
        rb[j] = line;
      end
      repeat (BIT) @(posedge sys_clk);
      rx_q.push_back(rb);
    end
  end
endmodule
`default_nettype wire

/* File: test/tb_dbgerr_debug_unit.sv */
/*
  Self-checking bench for the debug error and breakpoint block.
  Assumes the checker is bound and the host model drives the far side.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_dbgerr_debug_unit import dbgerr_pkg::*;;
  logic sys_clk, resetn, baud_locked, tx_valid, tx_ready, host_pull, listen, ok;
  logic debug_line_out, debug_line_oe_n, baud_reset, cmd_abort, cmd_full_enable;
  logic rx_strobe, core_stop, core_loop;
  logic [5:0]  stb;
  logic [7:0]  tx_data, ctl_wdata, ctl_rdata, status_rdata, rx_byte, rx_last;
  logic [15:0] cnt_wdata, cnt_rdata, pc, v;
  logic [7:0]  q [0:40];
  logic [8:0]  bit_period;
  wire logic   debug_line_in;
  int seed, n, k, failures, num_checks;
  assign debug_line_in = !(host_pull || !debug_line_oe_n);
  dbgerr_debug_unit i_dbgerr_debug_unit (
    .sys_clk(sys_clk), .resetn(resetn), .debug_line_in(debug_line_in),
    .debug_line_out(debug_line_out), .debug_line_oe_n(debug_line_oe_n),
    .baud_locked(baud_locked), .bit_period(bit_period), .baud_reset(baud_reset),
    .clk_switch(stb[5]), .cmd_abort(cmd_abort), .cmd_full_enable(cmd_full_enable),
    .rx_byte(rx_byte), .rx_strobe(rx_strobe), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .ctl_wr(stb[0]), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata),
    .status_rdata(status_rdata), .cnt_wr(stb[1]), .cnt_wdata(cnt_wdata),
    .cnt_byte_dec(stb[2]), .cnt_rdata(cnt_rdata), .brk_decoded(stb[3]),
    .pc_fetch(stb[4]), .pc(pc), .core_stop(core_stop), .core_loop(core_loop)
  );
  dbgerr_host #(.BIT(8)) i_dbgerr_host (
    .sys_clk(sys_clk), .line(debug_line_in), .listen(listen), .pull(host_pull)
  );
  function automatic logic [15:0] inv(input logic [15:0] s);
    return ~s;
  endfunction
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  // one strobe per call: 0 ctl, 1 cnt, 2 byte dec, 3 brk, 4 fetch, 5 clock switch
  task automatic req(input int s, input logic [15:0] d);
    @(posedge sys_clk);
    stb       <= 6'h01 << s;
    ctl_wdata <= d[7:0];
    cnt_wdata <= d;
    pc        <= d;
    @(posedge sys_clk);
    stb <= 6'h00;
    #1;
  endtask
  task automatic expect_break;
    for (k = 0; cmd_abort !== 1'b1 && k < 400; k++) tick(1);
    chk("abort", cmd_abort, 1);
    for (k = 0; debug_line_oe_n === 1'b0 && k < 5000; k++) tick(1);
    chk("brk_len", k, SEND_BREAK_CYCLES);
    chk("baud_rst", baud_reset, 1);
    for (k = 0; (!debug_line_in || baud_reset) && k < 1000; k++) tick(1);
    chk("baud_rst", baud_reset, 0);
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (rx_strobe === 1'b1) begin
      rx_last <= rx_byte;
    end
  end
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = !sys_clk;
  end
  // longest path is four 4096-cycle breaks plus the drain
  initial begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    close_out();
  end
  initial begin
    seed = 35597;
    {resetn, baud_locked, tx_valid, listen, stb, tx_data, ctl_wdata, cnt_wdata, pc} = '0;
    bit_period = 9'h008;
    rx_last = 8'h00;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    tick(2);
    chk("ctl", ctl_rdata, 16'h0000);
    chk("cnt", cnt_rdata, inv(CNT_RESET));
    chk("baud_rst", baud_reset, 0);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      v[7] = 1'b0;
      v[1] = 1'b0;
      req(0, v);
      chk("ctl", ctl_rdata & 8'hE3, v & 8'hE3);
      chk("full", cmd_full_enable, 0);
    end
    req(0, 16'h0000);
    req(3, 16'h0000);
    chk("stop", core_stop, 0);
    req(0, 16'h0040);
    req(3, 16'h0000);
    chk("stop", core_stop, 1);
    chk("stat", status_rdata[STAT_DBG_MODE], 1);
    chk("full", cmd_full_enable, 1);
    v = $random(seed) | 1;
    req(1, v);
    chk("cnt", cnt_rdata, inv(v));
    req(2, 16'h0000);
    chk("cnt", cnt_rdata, inv(v - 16'h0001));
    req(0, 16'h0060);
    chk("loop", core_loop, 1);
    req(3, 16'h0000);
    chk("idle", status_rdata[STAT_IDLE], 1);
    chk("stop", core_stop, 0);
    req(0, 16'h0040);
    req(3, 16'h0000);
    chk("mode", ctl_rdata[7], 1);
    req(0, 16'h0041);
    // exit is seen one cycle after the control write lands
    tick(1);
    chk("cnt", cnt_rdata, 0);
    tick(20);
    chk("cnt", cnt_rdata, 20);
    req(3, 16'h0000);
    v = cnt_rdata;
    tick(5);
    chk("cnt", cnt_rdata, v);
    req(1, 16'h000A);
    req(0, 16'h0042);
    tick(5);
    chk("stop", core_stop, 0);
    tick(10);
    chk("stop", core_stop, 1);
    chk("cnt", cnt_rdata, 16'hFFFF);
    v = $random(seed);
    req(1, v);
    req(0, 16'h0043);
    req(4, v ^ 16'h0001);
    chk("stop", core_stop, 0);
    req(4, v);
    chk("stop", core_stop, 1);
    chk("cnt", cnt_rdata, inv(v));
    req(0, 16'h0000);
    for (int i = 0; i < 41; i++) q[i] = $random(seed);
    @(posedge sys_clk);
    n = 0;
    tx_data  <= q[0];
    tx_valid <= 1'b1;
    repeat (40) begin
      #1 ok = tx_ready;
      @(posedge sys_clk);
      if (ok) begin
        n++;
        tx_data <= q[n];
      end
    end
    tx_valid    <= 1'b0;
    listen      <= 1'b1;
    baud_locked <= 1'b1;
    chk("fill", n, FIFO_DEPTH);
    for (k = 0; i_dbgerr_host.rx_q.size() < FIFO_DEPTH && k < 2500; k++) tick(1);
    for (int i = 0; i < FIFO_DEPTH; i++) chk("tx", i_dbgerr_host.rx_q[i], q[i]);
    chk("ready", tx_ready, 1);
    listen = 1'b0;
    req(0, 16'h00C0);
    fork
      i_dbgerr_host.hold_low(4500);
      expect_break();
    join
    chk("ctl", ctl_rdata, 16'h00C0);
    chk("full", cmd_full_enable, 1);
    i_dbgerr_host.send_char(8'h80, 1'b1);
    tick(10);
    chk("rx", rx_last, 16'h0080);
    fork
      i_dbgerr_host.send_char(8'h55, 1'b0);
      expect_break();
    join
    @(posedge sys_clk);
    tx_data  <= 8'hFF;
    tx_valid <= 1'b1;
    @(posedge sys_clk);
    tx_valid <= 1'b0;
    fork
      begin
        for (n = 0; debug_line_oe_n !== 1'b0 && n < 50; n++) tick(1);
        tick(12);
        i_dbgerr_host.hold_low(16);
      end
      expect_break();
    join
    @(posedge sys_clk);
    baud_locked <= 1'b0;
    req(5, 16'h0000);
    chk("abort", cmd_abort, 0);
    @(posedge sys_clk);
    baud_locked <= 1'b1;
    fork
      req(5, 16'h0000);
      expect_break();
    join
    close_out();
  end
endmodule
`default_nettype wire
